//--- inc/pump_status_defines.vh
// Constants for the pump controller status word block
`ifndef PUMP_STATUS_DEFINES_VH
`define PUMP_STATUS_DEFINES_VH

`define ADDR_W 4
`define ADDR_STATUS 4'h0
`define ADDR_CONTROL 4'h1
`define ADDR_DWELL 4'h2
`define ADDR_FAULT_CODE 4'h3

`define BIT_INIT 0
`define BIT_CONFIGURED 1
`define BIT_FAULTED 2
`define BIT_MOTION_OFF 4
`define BIT_REF_REQ 5
`define BIT_LOAD_REQ 6
`define BIT_NO_PORTS 7
`define BIT_RDY_IDLE 8
`define BIT_RDY_PROD 9
`define BIT_RDY_FLUID 10
`define BIT_RDY_REF 11
`define BIT_RDY_LOAD 12
`define BIT_BLOCKED 15
`define BIT_BUSY_ANY 16
`define BIT_BUSY_PROD 17
`define BIT_BUSY_FLUID 18
`define BIT_BUSY_REF 19
`define BIT_BUSY_LOAD 20
`define BIT_BUSY_PORT 21
`define BIT_CHAMBER_FULL 25
`define BIT_SUCCESS_PULSE 26
`define BIT_SUCCESS_LAST 27

`define CMD_STOP 1
`define CMD_START_PROD 2
`define CMD_START_FLUID 3
`define CMD_START_REF 4
`define CMD_CLEAR_FAULT 5
`define CMD_START_LOAD 7
`define CMD_START_REQ 13

`define INIT_TIME_US 10
`define CLK_MHZ 25
`define INIT_CYCLES (`INIT_TIME_US * `CLK_MHZ)
`define INIT_W 9
`define DWELL_W 16
`define ZERO32 32'h0000_0000
`define ZERO16 16'h0000

`endif

//--- hdl/rise_detect.v
// Rising edge detector for one command bit
`timescale 1ns/1ps
module rise_detect
(
  input wire clk_in,
  input wire rst_in,
  input wire level_in,
  output wire rise_out
);
  reg last;

  always @(posedge clk_in)
  begin
    if (rst_in)
      last <= 1'b0;
    else
      last <= level_in;
  end

  assign rise_out = level_in & ~last;
endmodule // rise_detect

//--- hdl/pump_status.v
// Pump controller status word with command edge handling
//
// What this block does
// - Bit 0 low during init after reset, high once init finished.
// - Bit 1 follows actuator configured state.
// - Bit 4 is one whenever motion is inhibited.
// - Bit 5 set when homing required; then no other operation starts.
// - Bit 6 set when load outstanding; blocks production start.
// - Bit 7 set when all ports disabled; blocks every start.
// - Bit 8 high only while a general start is accepted.
// - Bit 9 high only while production start is accepted.
// - Bit 10 high only while fluidic start is accepted.
// - Bit 11 high only while reference start is accepted.
// - Bit 12 high only while load start is accepted.
// - Bit 15 set when load, reference or fault blocks production; bit 2 fault.
// - Bit 16 high while any operation of any class runs.
// - Bits 17 to 21 flag busy production, fluidic, reference, load, port.
// - Bit 25 high while piston at full-chamber position.
// - Bit 26 pulses after fault-free dispense, length from dwell setting.
// - Bit 27 set on good dispense, cleared on bad; zero at power-up.
// - Production start edge acts only when production-ready is one.
// - Clear-fault edge clears a present fault with nonzero code.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "pump_status_defines.vh"
module pump_status
(
  input wire clk_in,
  input wire rst_in,
  input wire [`ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  input wire configured_in,
  input wire motion_inhibit_in,
  input wire ref_required_in,
  input wire load_required_in,
  input wire ports_enabled_in,
  input wire chamber_full_in,
  input wire porting_in,
  input wire fault_set_in,
  input wire [15:0] fault_code_in,
  input wire prod_mode_in,
  input wire fluid_mode_in,
  input wire op_done_in,
  input wire op_stopped_short_in,
  output wire start_prod_out,
  output wire start_fluid_out,
  output wire start_ref_out,
  output wire start_load_out,
  output wire stop_out,
  output wire [31:0] status_out
);

  ////////////////////////////////////////////////////////////////////
  // Command word edges

  reg [31:0] command;
  reg [`DWELL_W-1:0] dwell;
  wire rise_stop;
  wire rise_prod;
  wire rise_fluid;
  wire rise_ref;
  wire rise_clear;
  wire rise_load;
  wire rise_req;

  rise_detect u_stop
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(command[`CMD_STOP]),
    .rise_out(rise_stop)
  );
  rise_detect u_prod
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(command[`CMD_START_PROD]),
    .rise_out(rise_prod)
  );
  rise_detect u_fluid
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(command[`CMD_START_FLUID]),
    .rise_out(rise_fluid)
  );
  rise_detect u_ref
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(command[`CMD_START_REF]),
    .rise_out(rise_ref)
  );
  rise_detect u_clear
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(command[`CMD_CLEAR_FAULT]),
    .rise_out(rise_clear)
  );
  rise_detect u_load
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(command[`CMD_START_LOAD]),
    .rise_out(rise_load)
  );
  rise_detect u_req
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(command[`CMD_START_REQ]),
    .rise_out(rise_req)
  );

  ////////////////////////////////////////////////////////////////////
  // Initialisation and fault

  reg [`INIT_W-1:0] init_count;
  reg initialized;
  reg faulted;
  reg [15:0] fault_code;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      init_count <= {`INIT_W{1'b0}};
      initialized <= 1'b0;
    end
    else if (!initialized)
    begin
      init_count <= init_count + 1'b1;
      if (init_count == `INIT_CYCLES - 1)
        initialized <= 1'b1;
    end
  end

  // A new fault beats a clear arriving in the same cycle
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      faulted <= 1'b0;
      fault_code <= `ZERO16;
    end
    else if (fault_set_in)
    begin
      faulted <= 1'b1;
      fault_code <= fault_code_in;
    end
    else if ((rise_clear || (rise_req && faulted)) && faulted &&
             fault_code != `ZERO16)
    begin
      faulted <= 1'b0;
      fault_code <= `ZERO16;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Readiness

  reg busy_prod;
  reg busy_fluid;
  reg busy_ref;
  reg busy_load;
  wire busy_any;
  wire rdy_idle;
  wire rdy_prod;
  wire rdy_fluid;
  wire rdy_ref;
  wire rdy_load;
  wire blocked;

  assign busy_any = busy_prod | busy_fluid | busy_ref | busy_load |
                    porting_in;
  assign rdy_idle = initialized & configured_in & ~faulted &
                    ~motion_inhibit_in & ports_enabled_in & ~busy_any;
  assign rdy_ref = rdy_idle;
  assign rdy_load = rdy_idle & ~ref_required_in;
  assign rdy_fluid = rdy_idle & ~ref_required_in &
                     (fluid_mode_in | prod_mode_in);
  assign blocked = load_required_in | ref_required_in | faulted;
  assign rdy_prod = rdy_idle & ~blocked & prod_mode_in;

  // Start required runs the reference first, then the load
  wire go_prod = rise_prod & rdy_prod;
  wire go_fluid = rise_fluid & rdy_fluid;
  wire go_ref = (rise_ref | (rise_req & ref_required_in)) & rdy_ref;
  wire go_load = (rise_load | (rise_req & ~ref_required_in &
                 load_required_in)) & rdy_load;

  assign start_prod_out = go_prod;
  assign start_fluid_out = go_fluid;
  assign start_ref_out = go_ref;
  assign start_load_out = go_load;
  assign stop_out = rise_stop;

  ////////////////////////////////////////////////////////////////////
  // Operation tracking

  wire op_end = op_done_in | op_stopped_short_in;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      busy_prod <= 1'b0;
      busy_fluid <= 1'b0;
      busy_ref <= 1'b0;
      busy_load <= 1'b0;
    end
    else
    begin
      busy_prod <= go_prod | (busy_prod & ~op_end);
      busy_fluid <= go_fluid | (busy_fluid & ~op_end);
      busy_ref <= go_ref | (busy_ref & ~op_end);
      busy_load <= go_load | (busy_load & ~op_end);
    end
  end

  // Dispense result
  reg success_last;
  reg success_pulse;
  reg [`DWELL_W-1:0] pulse_count;
  wire good_end = busy_prod & op_done_in & ~op_stopped_short_in &
                  ~faulted & ~fault_set_in;
  wire bad_end = busy_prod & (op_stopped_short_in | (op_done_in & ~good_end));

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      success_last <= 1'b0;
      success_pulse <= 1'b0;
      pulse_count <= {`DWELL_W{1'b0}};
    end
    else
    begin
      if (good_end)
        success_last <= 1'b1;
      else if (bad_end)
        success_last <= 1'b0;
      // A zero dwell still gives a one-cycle pulse
      if (good_end)
      begin
        success_pulse <= 1'b1;
        pulse_count <= dwell;
      end
      else if (success_pulse)
      begin
        if (pulse_count == {`DWELL_W{1'b0}})
          success_pulse <= 1'b0;
        else
          pulse_count <= pulse_count - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status word and register port

  reg [31:0] status;

  always @*
  begin
    status = `ZERO32;
    status[`BIT_INIT] = initialized;
    status[`BIT_CONFIGURED] = configured_in;
    status[`BIT_FAULTED] = faulted;
    status[`BIT_MOTION_OFF] = motion_inhibit_in;
    status[`BIT_REF_REQ] = ref_required_in;
    status[`BIT_LOAD_REQ] = load_required_in;
    status[`BIT_NO_PORTS] = ~ports_enabled_in;
    status[`BIT_RDY_IDLE] = rdy_idle;
    status[`BIT_RDY_PROD] = rdy_prod;
    status[`BIT_RDY_FLUID] = rdy_fluid;
    status[`BIT_RDY_REF] = rdy_ref;
    status[`BIT_RDY_LOAD] = rdy_load;
    status[`BIT_BLOCKED] = blocked;
    status[`BIT_BUSY_ANY] = busy_any;
    status[`BIT_BUSY_PROD] = busy_prod;
    status[`BIT_BUSY_FLUID] = busy_fluid;
    status[`BIT_BUSY_REF] = busy_ref;
    status[`BIT_BUSY_LOAD] = busy_load;
    status[`BIT_BUSY_PORT] = porting_in;
    status[`BIT_CHAMBER_FULL] = chamber_full_in;
    status[`BIT_SUCCESS_PULSE] = success_pulse;
    status[`BIT_SUCCESS_LAST] = success_last;
  end

  assign status_out = status;

  // Status address has no write path, so writes there vanish
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      command <= `ZERO32;
      dwell <= {`DWELL_W{1'b0}};
    end
    else if (wr_in)
    begin
      if (addr_in == `ADDR_CONTROL)
        command <= wdata_in;
      else if (addr_in == `ADDR_DWELL)
        dwell <= wdata_in[`DWELL_W-1:0];
    end
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= `ZERO32;
    else if (rd_in)
    begin
      case (addr_in)
        `ADDR_STATUS: rdata_out <= status;
        `ADDR_CONTROL: rdata_out <= command;
        `ADDR_DWELL: rdata_out <= {`ZERO16, dwell};
        `ADDR_FAULT_CODE: rdata_out <= {`ZERO16, fault_code};
        default: rdata_out <= `ZERO32;
      endcase
    end
    else
      rdata_out <= `ZERO32;
  end
endmodule // pump_status

//--- tb/pump_status_chk_assertions.sv
// Port assertions for the pump status word
`timescale 1ns/1ps
module pump_status_chk
(
  input wire clk_in,
  input wire rst_in,
  input wire configured_in,
  input wire motion_inhibit_in,
  input wire ports_enabled_in,
  input wire chamber_full_in,
  input wire op_done_in,
  input wire op_stopped_short_in,
  input wire fault_set_in,
  input wire start_prod_out,
  input wire start_fluid_out,
  input wire start_ref_out,
  input wire start_load_out,
  input wire [31:0] status_out
);
  wire go = start_prod_out | start_fluid_out | start_load_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////
  reserved_zero_a:
    assert property ((status_out & 32'hF1C0_6008) == 0) else $error("rsvd");
  level_view_a:
    assert property ({status_out[1], status_out[4], status_out[7],
      status_out[25]} == {configured_in, motion_inhibit_in,
      !ports_enabled_in, chamber_full_in}) else $error("level flag");
  init_low_a:
    assert property ($fell(rst_in) |-> !status_out[0]) else $error("init");
  busy_any_a:
    assert property (status_out[16] == |status_out[21:17]) else $error("any");
  blocked_flag_a:
    assert property (|status_out[6:5] || status_out[2] |-> status_out[15])
      else $error("blocked");
  prod_gate_a:
    assert property (start_prod_out |-> status_out[9] && !status_out[6])
      else $error("prod gate");
  ref_gate_a:
    assert property (status_out[5] |-> !go) else $error("ref gate");
  ports_gate_a:
    assert property (!ports_enabled_in |-> !go && !start_ref_out &&
      !status_out[8]) else $error("port gate");
  ready_gate_a:
    assert property ((start_fluid_out |-> status_out[10]) and
      (start_ref_out |-> status_out[11]) and
      (start_load_out |-> status_out[12])) else $error("ready gate");
  fault_latch_a:
    assert property (fault_set_in |=> status_out[2] && status_out[15])
      else $error("fault latch");
  start_busy_a:
    assert property (start_prod_out |=> status_out[17]) else $error("busy");
  success_flag_a:
    assert property (op_done_in && status_out[17] && !status_out[2] &&
      !fault_set_in && !op_stopped_short_in
      |=> status_out[26] && status_out[27]) else $error("success");
  short_stop_a:
    assert property (op_stopped_short_in && status_out[17] |=> !status_out[27])
      else $error("short");
  cover property (start_prod_out);
  cover property (op_done_in && status_out[17]);
  cover property (status_out[2]);
  cover property (start_ref_out);
endmodule // pump_status_chk

bind pump_status pump_status_chk u_chk (.clk_in, .rst_in, .configured_in,
  .motion_inhibit_in, .ports_enabled_in, .chamber_full_in, .op_done_in,
  .op_stopped_short_in, .fault_set_in, .start_prod_out, .start_fluid_out,
  .start_ref_out, .start_load_out, .status_out);

//--- tb/plc_model.sv
// Controller model that reads and writes the status block registers
`timescale 1ns/1ps
module plc_model
(
  input wire clk_in,
  input wire [31:0] rdata_in,
  output logic [3:0] addr_out = 4'h0,
  output logic [31:0] wdata_out = 32'h0000_0000,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0
);
  task wr(input logic [3:0] a, input logic [31:0] v);
    begin
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= v;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
    end
  endtask
  // Data stand one cycle only, so take them mid-cycle
  task rd(input logic [3:0] a, output logic [31:0] v);
    begin
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      @(negedge clk_in);
      v = rdata_in;
    end
  endtask
  // Commands act on a rising bit, so the word is cleared first
  task cmd(input integer b);
    begin
      wr(4'h1, 32'h0000_0000);
      wr(4'h1, 32'h0000_0001 << b);
    end
  endtask
endmodule // plc_model

//--- tb/pump_status_tb_top.sv
// Self-checking bench for the pump status word
`timescale 1ns/1ps
`include "pump_status_defines.vh"
module pump_status_tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [6:0] lv = 7'h00;
  logic fault_set_in = 1'b0;
  logic [15:0] fault_code_in = 16'h0000;
  logic prod_mode_in = 1'b0;
  logic fluid_mode_in = 1'b0;
  logic done = 1'b0;
  logic short_stop = 1'b0;
  logic last_ok = 1'b0;
  logic [31:0] d;
  logic [6:0] blk [3] = '{7'h15, 7'h19, 7'h01};
  wire [3:0] addr_in;
  wire [31:0] wdata_in, rdata_out, status_out;
  wire wr_in, rd_in, start_prod_out;
  wire start_fluid_out, start_ref_out, start_load_out, stop_out;
  wire [3:0] starts = {start_load_out, start_ref_out, start_fluid_out,
    start_prod_out};
  integer errors = 0, check_count = 0, i, n;
  // No fault and no operation but porting runs in the random phase, so all bits are known
  wire rdy_id = lv[0] && !lv[1] && lv[4] && !lv[6];
  wire [31:0] e = {4'h0, last_ok, 1'b0, lv[5], 3'h0, lv[6], 4'h0, lv[6],
    lv[2] | lv[3], 2'b00, rdy_id && !lv[2], rdy_id,
    rdy_id && !lv[2] && (fluid_mode_in || prod_mode_in),
    rdy_id && prod_mode_in && !(lv[2] | lv[3]), rdy_id,
    !lv[4], lv[3], lv[2], lv[1], 2'b00, lv[0], 1'b1};
  initial forever #20 clk_in = ~clk_in;
  plc_model u_plc (.clk_in, .rdata_in(rdata_out), .addr_out(addr_in),
    .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
  pump_status u_dut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .configured_in(lv[0]), .motion_inhibit_in(lv[1]),
    .ref_required_in(lv[2]), .load_required_in(lv[3]),
    .ports_enabled_in(lv[4]), .chamber_full_in(lv[5]), .porting_in(lv[6]),
    .fault_set_in, .fault_code_in, .prod_mode_in,
    .fluid_mode_in, .op_done_in(done), .op_stopped_short_in(short_stop),
    .start_prod_out, .start_fluid_out, .start_ref_out, .start_load_out,
    .stop_out, .status_out);
  ////////////////////
  task ck(input logic ok);
    begin
      check_count++;
      if (ok !== 1'b1)
      begin
        $display("CHECK FAILED %0t status mismatch", $time);
        errors++;
      end
    end
  endtask
  task complete_run;
    begin
      if (errors == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task run_prod(input logic good);
    begin
      u_plc.cmd(`CMD_START_PROD);
      @(negedge clk_in);
      ck(start_prod_out === 1'b1);
      @(negedge clk_in);
      ck(status_out[17] === 1'b1 && status_out[16] === 1'b1);
      @(posedge clk_in);
      done <= good;
      short_stop <= !good;
      @(posedge clk_in);
      done <= 1'b0;
      short_stop <= 1'b0;
      last_ok = good;
      n = 0;
      repeat (10) @(negedge clk_in) n += status_out[26];
      ck(n === (good ? 4 : 0));
      ck(status_out[27] === good && status_out[17] === 1'b0);
    end
  endtask
  task raise_fault(input logic [15:0] c);
    begin
      @(posedge clk_in);
      fault_set_in <= 1'b1;
      fault_code_in <= c;
      @(posedge clk_in);
      fault_set_in <= 1'b0;
      @(negedge clk_in);
      ck(status_out[2] === 1'b1 && status_out[15] === 1'b1);
      ck(status_out[8] === 1'b0 && status_out[9] === 1'b0);
    end
  endtask
  // Fluidic, reference and load runs end on the same done pulse, so one task serves all three
  task run_op(input integer b, input logic [3:0] s, input integer k);
    begin
      u_plc.cmd(b);
      @(negedge clk_in);
      ck(starts === s);
      @(negedge clk_in);
      ck(status_out[k] === |s && status_out[16] === |s);
      @(posedge clk_in);
      done <= 1'b1;
      @(posedge clk_in);
      done <= 1'b0;
      @(negedge clk_in);
      ck(status_out[21:16] === 6'h00);
    end
  endtask
  ////////////////////
  initial
  begin
    n = $urandom(32'hF187);
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    u_plc.rd(`ADDR_STATUS, d);
    ck(d[0] === 1'b0);
    n = 0;
    while (status_out[0] !== 1'b1 && n < 400)
    begin
      @(negedge clk_in);
      n++;
    end
    ck(n > 240 && n < 256);
    if (n == 400)
      complete_run;
    for (i = 0; i < 24; i++)
    begin
      @(posedge clk_in) lv <= 7'($urandom);
      fluid_mode_in <= 1'($urandom);
      u_plc.wr(`ADDR_STATUS, $urandom);
      u_plc.rd(`ADDR_STATUS, d);
      ck(d === e);
      u_plc.rd(4'(4 + i % 12), d);
      ck(d === 32'h0000_0000);
    end
    u_plc.wr(`ADDR_DWELL, 32'h0000_0003);
    @(posedge clk_in) prod_mode_in <= 1'b1;
    fluid_mode_in <= 1'b0;
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk_in) lv <= blk[i];
      u_plc.cmd(`CMD_START_PROD);
      @(negedge clk_in);
      ck(start_prod_out === 1'b0 && status_out[9] === 1'b0);
    end
    @(posedge clk_in) lv <= 7'h11;
    run_prod(1'b1);
    run_prod(1'b0);
    raise_fault(16'h0000);
    u_plc.cmd(`CMD_CLEAR_FAULT);
    repeat (2) @(negedge clk_in);
    ck(status_out[2] === 1'b1);
    raise_fault(16'(32'h0000_0001 + $urandom % 32'h0000_FFFF));
    u_plc.rd(`ADDR_FAULT_CODE, d);
    ck(d === {16'h0000, fault_code_in});
    u_plc.cmd(`CMD_CLEAR_FAULT);
    repeat (2) @(negedge clk_in);
    ck(status_out[2] === 1'b0);
    raise_fault(16'h00A5);
    u_plc.cmd(`CMD_START_REQ);
    repeat (2) @(negedge clk_in);
    ck(status_out[2] === 1'b0 && status_out[8] === 1'b1);
    run_op(`CMD_START_FLUID, 4'h2, 18);
    @(posedge clk_in) prod_mode_in <= 1'b0;
    run_op(`CMD_START_FLUID, 4'h0, 18);
    @(posedge clk_in) fluid_mode_in <= 1'b1;
    run_op(`CMD_START_FLUID, 4'h2, 18);
    run_op(`CMD_START_REF, 4'h4, 19);
    run_op(`CMD_START_LOAD, 4'h8, 20);
    @(posedge clk_in) lv <= 7'h13;
    run_op(`CMD_START_REF, 4'h0, 19);
    @(posedge clk_in) lv <= 7'h15;
    run_op(`CMD_START_LOAD, 4'h0, 20);
    run_op(`CMD_START_REQ, 4'h4, 19);
    @(posedge clk_in) lv <= 7'h19;
    run_op(`CMD_START_REQ, 4'h8, 20);
    u_plc.cmd(`CMD_STOP);
    @(negedge clk_in);
    ck(stop_out === 1'b1 && status_out[16] === 1'b0);
    complete_run;
  end
endmodule // pump_status_tb_top
